// ### verification/sms_matrix_model.sv
// Model of the 8 x 8 contact matrix behind the scanner.
// Assumes scan_hi drives columns; diodes make closed contacts wired-or.
`timescale 1ns/1ps
`default_nettype none
module sms_matrix_model (
   // Column enables and sensor states
   input wire logic [7:0] scan_hi_in,
   input wire logic [63:0] sensors_in,
   // Row returns
   output logic [7:0] rows_out
);
   always_comb begin
      // Pull-downs: open returns read low, also between passes
      rows_out = 8'h00;
      for (int c = 0; c < 8; c++) begin
         if (scan_hi_in[7 - c]) begin
            rows_out = rows_out | sensors_in[8 * c +: 8];
         end
      end
   end
endmodule // sms_matrix_model
`default_nettype wire

// ### verification/sms_scanner_bench.sv
// Bench for the sensor matrix scanner: chained passes against a matrix.
// Assumes sms_pkg and the model are compiled first; enable driven here.
`timescale 1ns/1ps
`default_nettype none
module sms_scanner_bench;
   import sms_pkg::*;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic start_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic done_out, busy_out, actuator_output;
   sms_scan_t scan;
   logic [7:0] rows;
   logic [63:0] cur, prev, chg;
   logic [63:0] sensors = 64'h0;
   logic [63:0] exp_cur = 64'h0;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   bit pending = 1'b0;
   logic [63:0] pats [4] = '{64'h8000_0004_0080_1001,
      64'h5a00_2004_00ff_10a5, 64'h0100_0004_0080_1000, 64'hffff_ffff_ffff_ffff};

   always #25 clock_in = ~clock_in;

   sms_scanner i_sms_scanner (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in), .start_in(start_in), .done_out(done_out),
      .busy_out(busy_out), .column_scan_port_out(scan),
      .row_return_port_in(rows), .current_map_out(cur),
      .previous_map_out(prev), .change_map_out(chg),
      .actuator_output(actuator_output));
   sms_matrix_model i_sms_matrix_model (.scan_hi_in(scan.scan_hi),
      .sensors_in(sensors), .rows_out(rows));

   task check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Ceiling well above five passes plus reset
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 1000) begin
         failures++;
         end_of_test();
      end
   end

   // One pass; btb raises the next start in the done cycle
   task run_pass(input logic [63:0] pat, input logic [63:0] nxt,
                 input bit btb);
      int k;
      if (!pending) begin
         sensors = pat;
         start_in = 1'b1;
         @(negedge clock_in);
      end
      start_in = 1'b0;
      for (int c = 0; c < 24; c++) begin
         k = c / 3;
         check(64'({scan, done_out, busy_out}), 64'({8'h80 >> k,
            ~(8'h80 >> k), 3'(k), 2'b01}));
         @(negedge clock_in);
      end
      check(64'({scan, done_out, busy_out}),
            64'({8'h00, 8'hff, 3'h0, 2'b10}));
      check(cur, pat);
      check(prev, exp_cur);
      check(chg, pat ^ exp_cur);
      if (btb) begin
         sensors = nxt;
         start_in = 1'b1;
      end
      pending = btb;
      exp_cur = pat;
      @(negedge clock_in);
      check(64'(actuator_output), 64'(pat[12] & pat[23] & pat[34] &
            ~pat[45] & ~pat[56]));
   endtask

   // Enable low mid-pass: scan holds, pass ends five cycles late
   task run_frozen(input logic [63:0] pat);
      sensors = pat;
      start_in = 1'b1;
      @(negedge clock_in);
      start_in = 1'b0;
      repeat (4) @(negedge clock_in);
      clk_en_in = 1'b0;
      repeat (5) @(negedge clock_in);
      check(64'({scan, done_out, busy_out}),
            64'({8'h40, 8'hbf, 3'h1, 2'b01}));
      clk_en_in = 1'b1;
      repeat (20) @(negedge clock_in);
      check(64'({scan, done_out, busy_out}),
            64'({8'h00, 8'hff, 3'h0, 2'b10}));
      check(cur, pat);
      check(prev, exp_cur);
      exp_cur = pat;
      @(negedge clock_in);
   endtask

   initial begin
      repeat (20) @(negedge clock_in);
      check(64'({scan, done_out, busy_out, actuator_output}),
            64'({8'h00, 8'hff, 3'h0, 3'b000}));
      check(cur | prev | chg, 64'h0);
      rst_n_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         run_pass(pats[i], pats[(i + 1) % 4], i < 2);
      end
      run_frozen(pats[1]);
      end_of_test();
   end
endmodule // sms_scanner_bench
`default_nettype wire

// ### verilog/sms_pkg.sv
// Types for the sensor matrix scanner.
// Assumes sms_regs.svh is on the include path.
`include "sms_regs.svh"
package sms_pkg;
   typedef enum logic [1:0] {sms_idle, sms_drive, sms_settle,
                             sms_capture} sms_state_t;
   // Column drive variants, all registered together
   typedef struct packed {
      logic [`SMS_COLS-1:0] scan_hi;
      logic [`SMS_COLS-1:0] scan_lo_n;
      logic [2:0] col_addr;
   } sms_scan_t;
   typedef struct packed {
      logic done;
      logic actuator;
      logic busy;
   } sms_status_t;
endpackage : sms_pkg

// ### verilog/sms_regs.svh
// Constants for the sensor matrix scanner.
// Assumes inclusion by the scanner package and design file only.
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH
`define SMS_COLS 8
`define SMS_ROWS 8
`define SMS_SCAN_FIRST 8'h80
`define SMS_MASK_MSB 7
`define SMS_COL_LAST 3'h7
`define SMS_COL_FIRST 3'h0
`define SMS_SENSE_A 12
`define SMS_SENSE_B 23
`define SMS_SENSE_C 34
`define SMS_SENSE_D 45
`define SMS_SENSE_E 56
`endif

// ### verilog/sms_scanner.sv
// Sensor matrix scanner: drives columns, captures rows, keeps two maps.
// Assumes row_return_port_in is asynchronous to clock_in (pins).
`timescale 1ns/1ps
`default_nettype none
`include "sms_regs.svh"
module sms_scanner (
   // Clock, reset, enable
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Control
   input wire logic start_in,
   output logic done_out,
   output logic busy_out,
   // Matrix
   output sms_pkg::sms_scan_t column_scan_port_out,
   input wire logic [`SMS_ROWS-1:0] row_return_port_in,
   // Maps and results
   output logic [`SMS_COLS*`SMS_ROWS-1:0] current_map_out,
   output logic [`SMS_COLS*`SMS_ROWS-1:0] previous_map_out,
   output logic [`SMS_COLS*`SMS_ROWS-1:0] change_map_out,
   output logic actuator_output
);
   import sms_pkg::*;

   localparam int NB = `SMS_COLS*`SMS_ROWS;

   // Two-stage sync of row pins; only stage two is read
   logic [`SMS_ROWS-1:0] row_s1_q, row_s2_q;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         row_s1_q <= '0;
         row_s2_q <= '0;
      end else if (clk_en_in) begin
         row_s1_q <= row_return_port_in;
         row_s2_q <= row_s1_q;
      end
   end

   function automatic logic [2:0] mask_to_addr(input logic [7:0] m);
      logic [2:0] a;
      a = '0;
      for (int i = 0; i < `SMS_COLS; i++)
         if (m[i]) a = 3'(`SMS_COL_LAST - 3'(i));
      return a;
   endfunction

   sms_state_t state_q, state_d;
   logic [7:0] mask_q, mask_d;
   logic [2:0] col_q, col_d;
   logic [7:0] cur_q [`SMS_COLS];
   logic [7:0] prv_q [`SMS_COLS];
   logic [7:0] cur_d [`SMS_COLS];
   logic [7:0] prv_d [`SMS_COLS];
   sms_scan_t scan_q, scan_d;
   sms_status_t stat_q, stat_d;
   logic [NB-1:0] cur_flat_q, cur_flat_d, prv_flat_q, prv_flat_d;
   logic [NB-1:0] chg_q, chg_d;

   always_comb begin
      state_d = state_q;
      mask_d = mask_q;
      col_d = col_q;
      cur_d = cur_q;
      prv_d = prv_q;
      stat_d = '{done: 1'b0, actuator: stat_q.actuator,
                 busy: stat_q.busy};
      unique case (state_q)
         sms_idle: begin
            if (start_in) begin
               mask_d = `SMS_SCAN_FIRST;
               col_d = `SMS_COL_FIRST;
               state_d = sms_drive;
               stat_d.busy = 1'b1;
            end
         end
         // Pins first show the new column at the edge after drive and
         // need two sync stages more, so each column dwells 3 cycles
         sms_drive: state_d = sms_settle;
         sms_settle: state_d = sms_capture;
         sms_capture: begin
            // Stage two now holds pins sampled a cycle after drive
            cur_d[col_q] = row_s2_q;
            prv_d[col_q] = cur_q[col_q];
            mask_d = {mask_q[0], mask_q[7:1]};
            col_d = 3'(col_q + 3'h1);
            if (mask_d[`SMS_MASK_MSB]) begin
               state_d = sms_idle;
               stat_d.done = 1'b1;
               stat_d.busy = 1'b0;
            end else begin
               state_d = sms_drive;
            end
         end
      endcase
      for (int c = 0; c < `SMS_COLS; c++) begin
         cur_flat_d[c*`SMS_ROWS +: `SMS_ROWS] = cur_d[c];
         prv_flat_d[c*`SMS_ROWS +: `SMS_ROWS] = prv_d[c];
      end
      chg_d = cur_flat_d ^ prv_flat_d;
      stat_d.actuator = cur_flat_d[`SMS_SENSE_A] &
                        cur_flat_d[`SMS_SENSE_B] &
                        cur_flat_d[`SMS_SENSE_C] &
                        !cur_flat_d[`SMS_SENSE_D] &
                        !cur_flat_d[`SMS_SENSE_E];
      // Columns idle (all off) between passes
      if (state_d == sms_idle) begin
         scan_d.scan_hi = '0;
         scan_d.scan_lo_n = '1;
      end else begin
         scan_d.scan_hi = mask_d;
         scan_d.scan_lo_n = ~mask_d;
      end
      scan_d.col_addr = mask_to_addr(mask_d);
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_q <= sms_idle;
         mask_q <= `SMS_SCAN_FIRST;
         col_q <= `SMS_COL_FIRST;
         scan_q <= '{scan_hi: '0, scan_lo_n: '1, col_addr: '0};
         stat_q <= '0;
         cur_flat_q <= '0;
         prv_flat_q <= '0;
         chg_q <= '0;
         for (int c = 0; c < `SMS_COLS; c++) begin
            cur_q[c] <= '0;
            prv_q[c] <= '0;
         end
      end else if (clk_en_in) begin
         state_q <= state_d;
         mask_q <= mask_d;
         col_q <= col_d;
         scan_q <= scan_d;
         stat_q <= stat_d;
         cur_flat_q <= cur_flat_d;
         prv_flat_q <= prv_flat_d;
         chg_q <= chg_d;
         cur_q <= cur_d;
         prv_q <= prv_d;
      end
   end

   assign column_scan_port_out = scan_q;
   assign done_out = stat_q.done;
   assign busy_out = stat_q.busy;
   assign current_map_out = cur_flat_q;
   assign previous_map_out = prv_flat_q;
   assign change_map_out = chg_q;
   assign actuator_output = stat_q.actuator;

   a_scan_onehot: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      busy_out |-> $onehot(column_scan_port_out.scan_hi))
      else $error("scan enables not one-hot while busy");
   a_idle_off: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      !busy_out |-> column_scan_port_out.scan_hi == '0)
      else $error("column enabled while not busy");
   a_scan_lo_inv: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      column_scan_port_out.scan_lo_n == ~column_scan_port_out.scan_hi)
      else $error("active-low enables not inverse of scan");
   a_scan_first: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (clk_en_in && state_q == sms_idle && start_in)
      |=> column_scan_port_out.scan_hi == `SMS_SCAN_FIRST)
      else $error("first column not msb");
   // Mask one cycle back: by the next edge mask_q has moved on
   a_scan_rotate: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (clk_en_in && state_q == sms_capture && !stat_d.done)
      |=> column_scan_port_out.scan_hi ==
          $past({mask_q[0], mask_q[7:1]}))
      else $error("scan did not rotate right");
   a_col_dwell: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (clk_en_in && busy_out && state_q != sms_capture)
      |=> $stable(column_scan_port_out.scan_hi))
      else $error("column changed before capture");
   a_addr_match: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      busy_out |-> column_scan_port_out.scan_hi[`SMS_COLS-1 -
         int'(column_scan_port_out.col_addr)])
      else $error("column address disagrees with enables");
   a_store_prev: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (clk_en_in && state_q == sms_capture)
      |=> cur_q[$past(col_q)] == $past(row_s2_q) &&
          prv_q[$past(col_q)] == $past(cur_q[col_q]))
      else $error("map store wrong");
   a_done_pulse: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (done_out && clk_en_in) |=> !done_out)
      else $error("done longer than one cycle");
   a_pass_len: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      (clk_en_in && state_q == sms_capture && col_q == `SMS_COL_LAST)
      |=> done_out)
      else $error("pass did not end after eighth column");
   a_actuator: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      actuator_output == (current_map_out[`SMS_SENSE_A] &
         current_map_out[`SMS_SENSE_B] & current_map_out[`SMS_SENSE_C] &
         !current_map_out[`SMS_SENSE_D] & !current_map_out[`SMS_SENSE_E]))
      else $error("actuator mismatch");
   a_change_map: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      change_map_out == (current_map_out ^ previous_map_out))
      else $error("change map mismatch");
   a_freeze_hold: assert property (@(posedge clock_in)
      disable iff (!rst_n_in)
      !clk_en_in |=> $stable(column_scan_port_out) &&
         $stable(current_map_out) && $stable(done_out))
      else $error("state moved while clock enable low");
endmodule // sms_scanner
`default_nettype wire
